// >>> logic/qdr_pkg.sv
`default_nettype none
package qdr_pkg;
  // Fixed part of the seven-bit slave address
  localparam logic [4:0] ADDR_PFX   = 5'h13;
  // High-speed master code prefix, low three bits free
  localparam logic [4:0] MCODE_PFX  = 5'h01;
  localparam logic [3:0] BITS_BYTE  = 4'h8;
  localparam logic [1:0] LOAD_TEMP  = 2'h0;
  localparam logic [1:0] LOAD_BCAST = 2'h3;
  // Control byte fields
  localparam int CTL_EXT_HI  = 7;
  localparam int CTL_EXT_LO  = 6;
  localparam int CTL_LOAD_HI = 5;
  localparam int CTL_LOAD_LO = 4;
  localparam int CTL_CH_HI   = 2;
  localparam int CTL_CH_LO   = 1;
  localparam int CTL_KIND    = 0;
  // Top two bits of a data or power-down byte
  localparam int TOP_HI      = 7;
  localparam int TOP_LO      = 6;
  localparam int FIFO_DEPTH  = 32;

  typedef enum logic [7:0] {
    QDR_IDLE = 8'h01,
    QDR_ADDR = 8'h02,
    QDR_CTRL = 8'h04,
    QDR_DHI  = 8'h08,
    QDR_DLO  = 8'h10,
    QDR_PHI  = 8'h20,
    QDR_PLO  = 8'h40,
    QDR_SKIP = 8'h80
  } qdr_state_t;

  // One received update for the converter core
  typedef struct packed {
    logic [1:0] chan;
    logic [1:0] load;
    logic       upd;
    logic       pd;
    logic [1:0] pd_mode;
    logic [9:0] data;
  } qdr_rec_t;
endpackage
`default_nettype wire

// >>> logic/qdr_rx.sv
`default_nettype none
// Behaviour
// - Control byte: select bits, load action, ignored bit, channel, data kind.
// - Control byte bit zero chooses conversion data or power-down data.
// - Kind zero: high/low data pairs repeat until stop or repeated start.
// - High byte holds D9..D2; low byte top two bits D1, D0, rest ignored.
// - Kind one: exactly two power-down bytes follow the control byte.
// - The high-speed master code is never acknowledged.
// - Matching write address after a restart is acknowledged, SDA low.
// - Control byte with matching select bits or broadcast load, and later data or power-down bytes, get acknowledged.
// - Update released at the falling edge ending the low byte acknowledge.
// - Load action 00 writes only the holding register, no converter update.
module qdr_fifo #(
  parameter int W = 18,
  parameter int D = 32
) (
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         sys_rst_in,
  // Fill side
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  input  wire logic [W-1:0] in_data_in,
  // Drain side
  output logic              out_valid_out,
  input  wire logic         out_ready_in,
  output logic [W-1:0]      out_data_out
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  logic          wr_en;
  logic          rd_en;

  assign in_ready_out  = (cnt_q != (AW+1)'(D));
  assign out_valid_out = (cnt_q != '0);
  assign out_data_out  = mem_q[rd_q];
  assign wr_en = in_valid_in && in_ready_out;
  assign rd_en = out_valid_out && out_ready_in;

  always_ff @(posedge clk_in) begin
    if (wr_en) begin
      mem_q[wr_q] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (wr_en) begin
        wr_q <= (wr_q == AW'(D-1)) ? '0 : wr_q + 1'b1;
      end
      if (rd_en) begin
        rd_q <= (rd_q == AW'(D-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(wr_en) - (AW+1)'(rd_en);
    end
  end
endmodule

module qdr_rx (
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              sys_rst_in,
  // Two-wire bus pins
  input  wire logic              scl_in,
  output logic                   scl_out,
  output logic                   scl_oe_out,
  input  wire logic              sda_in,
  output logic                   sda_out,
  output logic                   sda_oe_out,
  // Address straps
  input  wire logic              addr_sel_0_in,
  input  wire logic              addr_sel_1_in,
  input  wire logic              ext_addr_sel_2_in,
  input  wire logic              ext_addr_sel_3_in,
  // Update stream to the converter core
  output logic                   upd_valid_out,
  input  wire logic              upd_ready_in,
  output qdr_pkg::qdr_rec_t      upd_rec_out
);
  logic [2:0] scl_s;
  logic [2:0] sda_s;
  logic [1:0] a01_s1, a01_s2, a23_s1, a23_s2;
  logic       scl_rise, scl_fall, start_c, stop_c, byte_done, ack_end;
  logic       addr_hit, ctrl_hit, fifo_ready;
  qdr_pkg::qdr_state_t state_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic [7:0] hi_q;
  logic [1:0] pdm_q;
  logic [1:0] chan_q;
  logic [1:0] load_q;
  logic       ack_q, inack_q, arm_q, pend_q;
  qdr_pkg::qdr_rec_t rec_q;

  // Bus pins and straps come from outside; two stages before any use
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      scl_s  <= 3'h7;
      sda_s  <= 3'h7;
      a01_s1 <= 2'h0;
      a01_s2 <= 2'h0;
      a23_s1 <= 2'h0;
      a23_s2 <= 2'h0;
    end else begin
      scl_s  <= {scl_s[1:0], scl_in};
      sda_s  <= {sda_s[1:0], sda_in};
      a01_s1 <= {addr_sel_1_in, addr_sel_0_in};
      a01_s2 <= a01_s1;
      a23_s1 <= {ext_addr_sel_3_in, ext_addr_sel_2_in};
      a23_s2 <= a23_s1;
    end
  end

  assign scl_rise  = scl_s[1] && !scl_s[2];
  assign scl_fall  = !scl_s[1] && scl_s[2];
  assign start_c   = scl_s[1] && scl_s[2] && !sda_s[1] && sda_s[2];
  assign stop_c    = scl_s[1] && scl_s[2] && sda_s[1] && !sda_s[2];
  assign byte_done = scl_fall && !inack_q && (cnt_q == qdr_pkg::BITS_BYTE);
  assign ack_end   = scl_fall && inack_q;
  // The master code fails the prefix, so it never matches
  assign addr_hit  = (sh_q[7:1] == {qdr_pkg::ADDR_PFX, a01_s2})
                     && !sh_q[0];
  // Broadcast loads answer whatever the upper select bits are
  assign ctrl_hit  = (sh_q[qdr_pkg::CTL_EXT_HI:qdr_pkg::CTL_EXT_LO] == a23_s2)
                     || (sh_q[qdr_pkg::CTL_LOAD_HI:qdr_pkg::CTL_LOAD_LO]
                         == qdr_pkg::LOAD_BCAST);

  // Bit shifter
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || start_c || stop_c) begin
      cnt_q <= 4'h0;
      sh_q  <= 8'h00;
    end else if (scl_rise && !inack_q && cnt_q != qdr_pkg::BITS_BYTE) begin
      sh_q  <= {sh_q[6:0], sda_s[1]};
      cnt_q <= cnt_q + 4'h1;
    end else if (ack_end) begin
      cnt_q <= 4'h0;
    end
  end

  // Byte sequencer and acknowledge driver
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || stop_c) begin
      state_q <= qdr_pkg::QDR_IDLE;
      ack_q   <= 1'b0;
      inack_q <= 1'b0;
      arm_q   <= 1'b0;
    end else if (start_c) begin
      state_q <= qdr_pkg::QDR_ADDR;
      ack_q   <= 1'b0;
      inack_q <= 1'b0;
      arm_q   <= 1'b0;
    end else if (ack_end) begin
      ack_q   <= 1'b0;
      inack_q <= 1'b0;
      arm_q   <= 1'b0;
    end else if (byte_done) begin
      inack_q <= 1'b1;
      ack_q   <= 1'b0;
      unique case (state_q)
        qdr_pkg::QDR_ADDR: begin
          ack_q   <= addr_hit;
          state_q <= addr_hit ? qdr_pkg::QDR_CTRL : qdr_pkg::QDR_SKIP;
        end
        qdr_pkg::QDR_CTRL: begin
          ack_q   <= ctrl_hit;
          if (!ctrl_hit) begin
            state_q <= qdr_pkg::QDR_SKIP;
          end else if (sh_q[qdr_pkg::CTL_KIND]) begin
            state_q <= qdr_pkg::QDR_PHI;
          end else begin
            state_q <= qdr_pkg::QDR_DHI;
          end
        end
        qdr_pkg::QDR_DHI: begin
          ack_q   <= 1'b1;
          state_q <= qdr_pkg::QDR_DLO;
        end
        qdr_pkg::QDR_DLO: begin
          ack_q   <= 1'b1;
          arm_q   <= 1'b1;
          state_q <= qdr_pkg::QDR_DHI;
        end
        qdr_pkg::QDR_PHI: begin
          ack_q   <= 1'b1;
          state_q <= qdr_pkg::QDR_PLO;
        end
        qdr_pkg::QDR_PLO: begin
          ack_q   <= 1'b1;
          arm_q   <= 1'b1;
          state_q <= qdr_pkg::QDR_SKIP;
        end
        qdr_pkg::QDR_IDLE, qdr_pkg::QDR_SKIP: begin
          ack_q   <= 1'b0;
        end
      endcase
    end
  end

  // Control and payload capture
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      chan_q <= 2'h0;
      load_q <= 2'h0;
      hi_q   <= 8'h00;
      pdm_q  <= 2'h0;
    end else if (byte_done) begin
      if (state_q == qdr_pkg::QDR_CTRL && ctrl_hit) begin
        chan_q <= sh_q[qdr_pkg::CTL_CH_HI:qdr_pkg::CTL_CH_LO];
        load_q <= sh_q[qdr_pkg::CTL_LOAD_HI:qdr_pkg::CTL_LOAD_LO];
      end
      if (state_q == qdr_pkg::QDR_DHI) begin
        hi_q <= sh_q;
      end
      if (state_q == qdr_pkg::QDR_PHI) begin
        pdm_q <= sh_q[qdr_pkg::TOP_HI:qdr_pkg::TOP_LO];
      end
    end
  end

  // Record release; SCL is stretched while the FIFO cannot take it
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pend_q        <= 1'b0;
      rec_q.chan    <= 2'h0;
      rec_q.load    <= 2'h0;
      rec_q.upd     <= 1'b0;
      rec_q.pd      <= 1'b0;
      rec_q.pd_mode <= 2'h0;
      rec_q.data    <= 10'h000;
    end else if (ack_end && arm_q) begin
      pend_q        <= 1'b1;
      rec_q.chan    <= chan_q;
      rec_q.load    <= load_q;
      rec_q.upd     <= (load_q != qdr_pkg::LOAD_TEMP);
      rec_q.pd      <= (state_q == qdr_pkg::QDR_SKIP);
      // Stale mode from an earlier power-down must not leak into data
      rec_q.pd_mode <= (state_q == qdr_pkg::QDR_SKIP) ? pdm_q : 2'h0;
      // Shifter still holds the low byte until the next bit arrives
      rec_q.data    <= {hi_q, sh_q[qdr_pkg::TOP_HI:qdr_pkg::TOP_LO]};
    end else if (pend_q && fifo_ready) begin
      pend_q        <= 1'b0;
    end
  end

  assign sda_out    = 1'b0;
  assign sda_oe_out = ack_q;
  assign scl_out    = 1'b0;
  assign scl_oe_out = pend_q && !fifo_ready;

  qdr_fifo #(
    .W ($bits(qdr_pkg::qdr_rec_t)),
    .D (qdr_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (clk_in),
    .sys_rst_in    (sys_rst_in),
    .in_valid_in   (pend_q),
    .in_ready_out  (fifo_ready),
    .in_data_in    (rec_q),
    .out_valid_out (upd_valid_out),
    .out_ready_in  (upd_ready_in),
    .out_data_out  (upd_rec_out)
  );

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  a_mcode_nack: assert property (
    byte_done && state_q == qdr_pkg::QDR_ADDR
    && sh_q[7:3] == qdr_pkg::MCODE_PFX |=> !ack_q [*2])
    else $error("master code acknowledged");
  a_addr_ack: assert property (
    byte_done && state_q == qdr_pkg::QDR_ADDR && addr_hit
    && !start_c && !stop_c |=> ack_q && state_q == qdr_pkg::QDR_CTRL)
    else $error("matching address not acknowledged");
  a_ctrl_decode: assert property (
    byte_done && state_q == qdr_pkg::QDR_CTRL && ctrl_hit |=>
    chan_q == $past(sh_q[2:1]) && load_q == $past(sh_q[5:4]))
    else $error("control fields not captured");
  a_kind_route: assert property (
    byte_done && state_q == qdr_pkg::QDR_CTRL && ctrl_hit && !stop_c
    && !start_c |=> state_q == ($past(sh_q[0]) ? qdr_pkg::QDR_PHI
                                               : qdr_pkg::QDR_DHI))
    else $error("data kind misrouted");
  a_ctrl_miss: assert property (
    byte_done && state_q == qdr_pkg::QDR_CTRL && !ctrl_hit && !stop_c
    && !start_c |=> !ack_q && state_q == qdr_pkg::QDR_SKIP)
    else $error("mismatched control acknowledged");
  a_pd_two_bytes: assert property (
    byte_done && state_q == qdr_pkg::QDR_PLO && !stop_c && !start_c
    |=> state_q == qdr_pkg::QDR_SKIP && ack_q)
    else $error("power-down sequence length wrong");
  a_data_loop: assert property (
    byte_done && state_q == qdr_pkg::QDR_DLO && !stop_c && !start_c
    |=> state_q == qdr_pkg::QDR_DHI && ack_q && arm_q)
    else $error("data pair loop broken");
  a_push_time: assert property (
    $rose(pend_q) |-> $past(ack_end && arm_q))
    else $error("update released off the acknowledge end");
  a_data_pack: assert property (
    $rose(pend_q) && !rec_q.pd |-> rec_q.data[9:2] == hi_q)
    else $error("data bits misplaced");
  a_load_temp: assert property (
    $rose(pend_q) |-> rec_q.upd == (rec_q.load != qdr_pkg::LOAD_TEMP))
    else $error("temporary-only load flagged for update");
endmodule
`default_nettype wire

// >>> dv/qdr_master.sv
`default_nettype none
module qdr_master (
  // Clock and bus levels
  input  wire logic clk_in,
  input  wire logic scl_in,
  input  wire logic sda_in,
  // Open-drain pulls, high while pulling low
  output var logic  scl_low_out,
  output var logic  sda_low_out
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    scl_low_out = 1'b0;
    sda_low_out = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  // A stretch holds us here; the high phase is timed from the real rise
  task automatic rise();
    scl_low_out = 1'b0;
    for (int i = 0; i < 4000 && scl_in !== 1'b1; i++) tick(1);
    tick(4);
  endtask

  // Also the repeated start that loops back to the address phase
  task automatic start();
    sda_low_out = 1'b0;
    tick(2);
    rise();
    sda_low_out = 1'b1;
    tick(4);
    scl_low_out = 1'b1;
    tick(2);
  endtask

  task automatic stop();
    sda_low_out = 1'b1;
    tick(2);
    rise();
    sda_low_out = 1'b0;
    tick(4);
  endtask

  // Flag only ever cleared, so one verdict can span several bytes
  task automatic send(input logic [7:0] b, inout logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_low_out = !b[i];
      tick(2);
      rise();
      scl_low_out = 1'b1;
      tick(2);
    end
    sda_low_out = 1'b0;
    tick(2);
    rise();
    ack &= !sda_in;
    scl_low_out = 1'b1;
    tick(2);
  endtask
endmodule
`default_nettype wire

// >>> dv/qdr_rx_tb.sv
`default_nettype none
module qdr_rx_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] ADR = {qdr_pkg::ADDR_PFX, 3'b010};
  logic              clk_in = 1'b0;
  logic              sys_rst_in = 1'b1;
  logic              upd_ready_in = 1'b0;
  logic              scl_oe, sda_oe, m_scl, m_sda, upd_valid, ok, a;
  qdr_pkg::qdr_rec_t rec;
  int                errors = 0;
  int                comparisons = 0;
  logic [41:0]       rows [6];
  // Pull-ups: a line is low while any party pulls it
  wire logic         scl = !(scl_oe || m_scl);
  wire logic         sda = !(sda_oe || m_sda);

  always #10 clk_in = ~clk_in;

  qdr_rx qdr_rx_i (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .scl_in(scl), .scl_out(),
    .scl_oe_out(scl_oe), .sda_in(sda), .sda_out(), .sda_oe_out(sda_oe),
    .addr_sel_0_in(1'b1), .addr_sel_1_in(1'b0),
    .ext_addr_sel_2_in(1'b0), .ext_addr_sel_3_in(1'b1),
    .upd_valid_out(upd_valid), .upd_ready_in(upd_ready_in),
    .upd_rec_out(rec)
  );

  qdr_master qdr_master_i (
    .clk_in(clk_in), .scl_in(scl), .sda_in(sda),
    .scl_low_out(m_scl), .sda_low_out(m_sda)
  );

  task automatic chk(input logic [17:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Data of a power-down record is meaningless, so it is masked off
  task automatic pop(input logic [17:0] exp);
    logic [17:0] m;
    m = exp[12] ? 18'h3fc00 : 18'h3ffff;
    for (int i = 0; i < 300 && upd_valid !== 1'b1; i++)
      @(negedge clk_in);
    chk(18'(upd_valid), 18'h1);
    chk(rec & m, exp);
    upd_ready_in = 1'b1;
    @(negedge clk_in);
    upd_ready_in = 1'b0;
  endtask

  task automatic wr(input logic [7:0] c, h, l);
    ok = 1'b1;
    qdr_master_i.start();
    qdr_master_i.send(ADR, ok);
    qdr_master_i.send(c, ok);
    qdr_master_i.send(h, ok);
    qdr_master_i.send(l, ok);
  endtask

  task automatic nak(input logic [7:0] x, y, input logic xa);
    ok = 1'b1;
    a = 1'b1;
    qdr_master_i.start();
    qdr_master_i.send(x, ok);
    qdr_master_i.send(y, a);
    qdr_master_i.stop();
    chk(18'({ok, a}), 18'({xa, 1'b0}));
  endtask

  initial begin
    repeat (30000) @(posedge clk_in);
    errors++;
    report_and_stop();
  end

  initial begin
    rows[0] = {8'h82, 8'hff, 8'hc0, 18'h103ff};
    rows[1] = {8'h94, 8'h5a, 8'hbf, 18'h2616a};
    rows[2] = {8'ha6, 8'h00, 8'h40, 18'h3a001};
    rows[3] = {8'h93, 8'hc0, 8'h00, 18'h17c00};
    rows[4] = {8'h7c, 8'h01, 8'hc0, 18'h2e007};
    rows[5] = {8'h81, 8'h40, 8'h00, 18'h01400};
    repeat (4) @(negedge clk_in);
    chk(18'({scl_oe, sda_oe, upd_valid}), 18'h0);
    sys_rst_in = 1'b0;
    repeat (4) @(negedge clk_in);
    for (int i = 0; i < 6; i++) begin
      wr(rows[i][41:34], rows[i][33:26], rows[i][25:18]);
      chk(18'(upd_valid), 18'h0);
      qdr_master_i.stop();
      chk(18'(ok), 18'h1);
      pop(rows[i][17:0]);
    end
    a = 1'b1;
    qdr_master_i.start();
    qdr_master_i.send(8'h0d, a);
    chk(18'(a), 18'h0);
    wr(8'h82, 8'h12, 8'h40);
    qdr_master_i.send(8'h34, ok);
    qdr_master_i.send(8'h00, ok);
    qdr_master_i.send(8'h55, ok);
    qdr_master_i.stop();
    chk(18'(ok), 18'h1);
    pop(18'h10049);
    pop(18'h100d0);
    repeat (40) @(negedge clk_in);
    chk(18'(upd_valid), 18'h0);
    nak(8'h9c, 8'h82, 1'b0);
    nak(8'h9b, 8'h82, 1'b0);
    nak(ADR, 8'h42, 1'b1);
    wr(8'h93, 8'h80, 8'h00);
    a = 1'b1;
    qdr_master_i.send(8'h00, a);
    qdr_master_i.stop();
    chk(18'({ok, a}), 18'h2);
    pop(18'h17800);
    // Consumer stalls until the full buffer stretches the clock
    fork
      begin
        wr(8'h82, 8'h00, 8'h00);
        for (int i = 1; i < 33; i++) begin
          qdr_master_i.send(8'(i), ok);
          qdr_master_i.send(8'h00, ok);
        end
        qdr_master_i.stop();
      end
      begin
        wait (scl_oe === 1'b1);
        repeat (30) @(negedge clk_in);
        chk(18'({scl_oe, upd_valid}), 18'h3);
        for (int i = 0; i < 33; i++)
          pop(18'h10000 | 18'(i << 2));
      end
    join
    repeat (40) @(negedge clk_in);
    chk(18'({ok, scl_oe, upd_valid}), 18'h4);
    report_and_stop();
  end
endmodule
`default_nettype wire
